// File: pkg/expander_cfg.svh
// constants of the expander control block: offsets, field positions, reset values
//
// Contract
// [R1] pin value bits show the selected expander: inputs as last fetched, outputs as driven
// [R2] pin value writes are dropped while the test override bit is clear
// [R3] with test override set, outputs sent to the expander come from software values
// [R4] pin value bits that are expander inputs stay read-only, even in test mode
// [R5] writing one to refresh request launches a transfer to the selected expander
// [R6] the refresh request bit always reads as zero
// [R7] in test mode a pin write with refresh set sends the written outputs
// [R8] select codes zero to four name expanders; other codes are reserved
// [R9] completion flag sets when a refresh transfer for the selected expander finishes
// [R10] in test mode, completion sets when the output-updating transfer finishes
// [R11] completion also sets when a written address's expander finishes initialisation; the code sets it only if that expander is the selected one
// [R12] writing one clears the completion flag; writing zero leaves it alone
// [R13] each expander has a seven-bit bus address used when addressing it
// [R14] software waits for and clears completion before starting another transfer
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define EXP_COUNT        5
`define EXP_PIN_W        16
`define EXP_IDX_W        3
`define REG_ADDR_W       12
`define REG_DATA_W       32
`define SYNC_STAGES      2

// ****************************************************************
// register offsets
// ****************************************************************
`define REG_CTRL_OFS     12'h430
`define REG_ADDR0_OFS    12'h434
`define REG_ADDR1_OFS    12'h438
`define REG_EVSTS_OFS    12'h440
`define REG_EVMSK_OFS    12'h444
`define REG_RESET        32'h0000_0000

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_PIN_LSB     0
`define CTRL_RELOAD_BIT  24
`define CTRL_TEST_BIT    25
`define CTRL_SEL_LSB     26
`define CTRL_SEL_W       4
`define CTRL_DONE_BIT    31
`define BUSADDR_W        7
`define BUSADDR_LSB      1
`define BUSADDR_STRIDE   8
`define ADDR0_FIELDS     4
`define EV_REFRESH_BIT   0
`define EV_INIT_BIT      1
`define EV_W             2
`define INPUT_MASK_DEF   80'h00FF_00FF_00FF_00FF_00FF

`endif

// File: pkg/smbus_io_expander_pkg.sv
// types shared by the expander control block
package smbus_io_expander_pkg;

   // ****************************************************************
   // transfer sequencer states, gray coded along idle-request-wait
   // ****************************************************************
   typedef enum logic [1:0] {
      XF_IDLE = 2'h0,
      XF_REQ  = 2'h1,
      XF_WAIT = 2'h3
   } xfer_state_t;

endpackage : smbus_io_expander_pkg

// File: rtl/link_capture.sv
// link capture: synchronises the link clock, frame and data, deserialises returned pin bits
`timescale 1ns/10ps
`include "expander_cfg.svh"

module link_capture #(
   parameter int W = `EXP_PIN_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         link_clk,
   input  wire logic         link_frame,
   input  wire logic         link_bit,
   output wire logic         frame_active,
   output wire logic         word_done,
   output wire logic [W-1:0] word_data
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [`SYNC_STAGES-1:0] clk_s;
      logic [`SYNC_STAGES-1:0] frm_s;
      logic [`SYNC_STAGES-1:0] bit_s;
      logic                    clk_d;
      logic                    frm_d;
      logic [W-1:0]            shift;
      logic                    done;
      logic [W-1:0]            data;
   } cap_t;

   cap_t cap_r;
   cap_t cap_nxt;

   // only the second stage of each synchroniser feeds the edge logic
   always_comb begin
      cap_nxt       = cap_r;
      cap_nxt.clk_s = {cap_r.clk_s[0], link_clk};
      cap_nxt.frm_s = {cap_r.frm_s[0], link_frame};
      cap_nxt.bit_s = {cap_r.bit_s[0], link_bit};
      cap_nxt.clk_d = cap_r.clk_s[1];
      cap_nxt.frm_d = cap_r.frm_s[1];
      cap_nxt.done  = 1'b0;
      // a fresh frame starts from an empty word
      if (cap_r.frm_s[1] && !cap_r.frm_d) begin
         cap_nxt.shift = '0;
      end else if (cap_r.frm_s[1] && cap_r.clk_s[1] && !cap_r.clk_d) begin
         cap_nxt.shift = {cap_r.shift[W-2:0], cap_r.bit_s[1]}; // msb first
      end
      // the frame's own end closes the word; the link clock may stop after it
      if (cap_r.frm_d && !cap_r.frm_s[1]) begin
         cap_nxt.done = 1'b1;
         cap_nxt.data = cap_r.shift;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_r <= '0;
      end else begin
         cap_r <= cap_nxt;
      end
   end

   assign frame_active = cap_r.frm_s[1];
   assign word_done    = cap_r.done;
   assign word_data    = cap_r.data;

endmodule : link_capture

// File: rtl/smbus_io_expander_control.sv
// expander control: register slave, transfer sequencer, completion flag and events
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "expander_cfg.svh"

module smbus_io_expander_control #(
   parameter logic [`EXP_COUNT*`EXP_PIN_W-1:0] INPUT_MASK = `INPUT_MASK_DEF
) (
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic [`REG_ADDR_W-1:0]            reg_addr,
   input  wire logic [`REG_DATA_W-1:0]            reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output wire logic [`REG_DATA_W-1:0]            reg_rdata,
   input  wire logic [`EXP_COUNT*`EXP_PIN_W-1:0]  core_out,
   output wire logic [`EXP_COUNT*`EXP_PIN_W-1:0]  exp_in_values,
   input  wire logic                              link_clk,
   input  wire logic                              link_frame,
   input  wire logic                              link_bit,
   output wire logic                              xfer_req,
   output wire logic                              xfer_init,
   output wire logic [`BUSADDR_W-1:0]             xfer_addr,
   output wire logic [`EXP_PIN_W-1:0]             xfer_wdata,
   output wire logic                              busy,
   output wire logic                              irq
);

   localparam int N  = `EXP_COUNT;
   localparam int PW = `EXP_PIN_W;
   localparam int IW = `EXP_IDX_W;
   localparam int SW = `CTRL_SEL_W;
   localparam int AW = `BUSADDR_W;
   localparam int EW = `EV_W;
   localparam int DW = `REG_DATA_W;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      smbus_io_expander_pkg::xfer_state_t st;
      logic [SW-1:0]         sel;
      logic                  test;
      logic                  done;
      logic [N-1:0][PW-1:0]  in_val;
      logic [N-1:0][PW-1:0]  tst_out;
      logic [N-1:0][AW-1:0]  bus_addr;
      logic                  pend_ref;
      logic [IW-1:0]         pend_id;
      logic [N-1:0]          pend_init;
      logic [IW-1:0]         cur;
      logic                  cur_init;
      logic [EW-1:0]         ev_sts;
      logic [EW-1:0]         ev_msk;
      logic                  req;
      logic                  x_init;
      logic [AW-1:0]         x_addr;
      logic [PW-1:0]         x_wdata;
      logic [DW-1:0]         rdata;
   } ctl_t;

   ctl_t state_r;
   ctl_t state_nxt;

   // ****************************************************************
   // helper functions
   // ****************************************************************
   // reserved select codes address nothing
   function automatic logic sel_ok(input logic [SW-1:0] s);
      sel_ok = (s < SW'(N));
   endfunction : sel_ok

   function automatic logic [PW-1:0] mask_of(input logic [IW-1:0] e);
      mask_of = INPUT_MASK[e*PW +: PW];
   endfunction : mask_of

   function automatic logic [PW-1:0] core_of(input logic [IW-1:0] e);
      core_of = core_out[e*PW +: PW];
   endfunction : core_of

   // test override replaces the internal logic's outputs
   function automatic logic [PW-1:0] drive_of(input logic t, input logic [PW-1:0] tv,
                                              input logic [PW-1:0] cv);
      drive_of = t ? tv : cv;
   endfunction : drive_of

   // lowest pending initialisation goes first
   function automatic logic [IW-1:0] first_set(input logic [N-1:0] p);
      first_set = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (p[i]) begin
            first_set = IW'(i);
         end
      end
   endfunction : first_set

   // ****************************************************************
   // link side capture
   // ****************************************************************
   logic          frame_active;
   logic          word_done;
   logic [PW-1:0] word_data;

   link_capture #(
      .W (PW)
   ) u_capture (
      .clk          (clk),
      .rst          (rst),
      .link_clk     (link_clk),
      .link_frame   (link_frame),
      .link_bit     (link_bit),
      .frame_active (frame_active),
      .word_done    (word_done),
      .word_data    (word_data)
   );

   // ****************************************************************
   // decode and derived values
   // ****************************************************************
   logic          ctrl_wr;
   logic          sts_wr;
   logic [SW-1:0] wsel;
   logic [IW-1:0] widx;
   logic [IW-1:0] sidx;
   logic          take_ref;
   logic          take_init;
   logic [IW-1:0] launch_id;
   logic          finish;
   logic [PW-1:0] pin_view;

   assign ctrl_wr   = reg_wr && (reg_addr == `REG_CTRL_OFS);
   assign sts_wr    = reg_wr && (reg_addr == `REG_EVSTS_OFS);
   assign wsel      = reg_wdata[`CTRL_SEL_LSB +: SW];
   assign widx      = wsel[IW-1:0];
   assign sidx      = state_r.sel[IW-1:0];
   assign take_ref  = (state_r.st == smbus_io_expander_pkg::XF_IDLE) && state_r.pend_ref;
   assign take_init = (state_r.st == smbus_io_expander_pkg::XF_IDLE) && !state_r.pend_ref
                      && (|state_r.pend_init);
   assign launch_id = state_r.pend_ref ? state_r.pend_id : first_set(state_r.pend_init);
   assign finish    = (state_r.st == smbus_io_expander_pkg::XF_WAIT) && word_done;

   // inputs as fetched, outputs as currently driven
   assign pin_view = sel_ok(state_r.sel) ?
                     ((state_r.in_val[sidx] & mask_of(sidx))
                      | (drive_of(state_r.test, state_r.tst_out[sidx], core_of(sidx)) & ~mask_of(sidx)))
                     : '0; // [R1] [R8]

   // ****************************************************************
   // next state
   // ****************************************************************
   // order: software clears, then hardware sets, so an event in the clear cycle survives
   always_comb begin
      state_nxt       = state_r;
      state_nxt.rdata = '0;
      if (ctrl_wr && reg_wdata[`CTRL_DONE_BIT]) begin
         state_nxt.done = 1'b0; // [R12]
      end
      if (sts_wr) begin
         state_nxt.ev_sts = state_r.ev_sts & ~reg_wdata[EW-1:0];
      end
      // transfer sequencer
      case (state_r.st)
         smbus_io_expander_pkg::XF_IDLE: begin
            if (take_ref || take_init) begin
               state_nxt.st       = smbus_io_expander_pkg::XF_REQ;
               state_nxt.req      = 1'b1; // [R5]
               state_nxt.cur      = launch_id;
               state_nxt.cur_init = take_init;
               state_nxt.x_init   = take_init;
               state_nxt.x_addr   = state_r.bus_addr[launch_id]; // [R13]
               state_nxt.x_wdata  = drive_of(state_r.test, state_r.tst_out[launch_id],
                                             core_of(launch_id)); // [R3] [R7]
               if (take_ref) begin
                  state_nxt.pend_ref = 1'b0;
               end else begin
                  state_nxt.pend_init[launch_id] = 1'b0;
               end
            end
         end
         smbus_io_expander_pkg::XF_REQ: begin
            // the engine owns the transfer once its frame is seen
            if (frame_active) begin
               state_nxt.req = 1'b0;
               state_nxt.st  = smbus_io_expander_pkg::XF_WAIT;
            end
         end
         smbus_io_expander_pkg::XF_WAIT: begin
            if (word_done) begin
               state_nxt.st                = smbus_io_expander_pkg::XF_IDLE;
               state_nxt.in_val[state_r.cur] = word_data; // [R1]
               if ({1'b0, state_r.cur} == state_r.sel) begin
                  state_nxt.done = 1'b1; // [R9] [R10] [R11]
               end
               if (state_r.cur_init) begin
                  state_nxt.ev_sts[`EV_INIT_BIT] = 1'b1;
               end else begin
                  state_nxt.ev_sts[`EV_REFRESH_BIT] = 1'b1;
               end
            end
         end
         default: begin
            state_nxt.st  = smbus_io_expander_pkg::XF_IDLE;
            state_nxt.req = 1'b0;
         end
      endcase
      // register writes that load or request
      if (ctrl_wr) begin
         state_nxt.test = reg_wdata[`CTRL_TEST_BIT];
         state_nxt.sel  = wsel; // [R8]
         // input positions keep their old value: only output bits take the write
         if (reg_wdata[`CTRL_TEST_BIT] && sel_ok(wsel)) begin
            state_nxt.tst_out[widx] = (state_r.tst_out[widx] & mask_of(widx))
                                      | (reg_wdata[`CTRL_PIN_LSB +: PW] & ~mask_of(widx)); // [R2] [R4]
         end
         // a request while one is still queued replaces it; software is expected to wait
         if (reg_wdata[`CTRL_RELOAD_BIT] && sel_ok(wsel)) begin
            state_nxt.pend_ref = 1'b1; // [R5] [R7]
            state_nxt.pend_id  = widx;
         end
      end
      if (reg_wr && (reg_addr == `REG_ADDR0_OFS)) begin
         for (int i = 0; i < `ADDR0_FIELDS; i++) begin
            state_nxt.bus_addr[i] = reg_wdata[`BUSADDR_LSB + i*`BUSADDR_STRIDE +: AW]; // [R13]
            state_nxt.pend_init[i] = 1'b1; // [R11]
         end
      end
      if (reg_wr && (reg_addr == `REG_ADDR1_OFS)) begin
         state_nxt.bus_addr[N-1]  = reg_wdata[`BUSADDR_LSB +: AW];
         state_nxt.pend_init[N-1] = 1'b1;
      end
      if (reg_wr && (reg_addr == `REG_EVMSK_OFS)) begin
         state_nxt.ev_msk = reg_wdata[EW-1:0];
      end
      // read data stand only in the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL_OFS: begin
               state_nxt.rdata                           = `REG_RESET;
               state_nxt.rdata[`CTRL_PIN_LSB +: PW]      = pin_view; // [R1]
               state_nxt.rdata[`CTRL_TEST_BIT]           = state_r.test;
               state_nxt.rdata[`CTRL_SEL_LSB +: SW]      = state_r.sel;
               state_nxt.rdata[`CTRL_DONE_BIT]           = state_r.done;
               state_nxt.rdata[`CTRL_RELOAD_BIT]         = 1'b0; // [R6]
            end
            `REG_ADDR0_OFS: begin
               state_nxt.rdata = `REG_RESET;
               for (int i = 0; i < `ADDR0_FIELDS; i++) begin
                  state_nxt.rdata[`BUSADDR_LSB + i*`BUSADDR_STRIDE +: AW] = state_r.bus_addr[i];
               end
            end
            `REG_ADDR1_OFS: begin
               state_nxt.rdata                       = `REG_RESET;
               state_nxt.rdata[`BUSADDR_LSB +: AW]   = state_r.bus_addr[N-1];
            end
            `REG_EVSTS_OFS: begin
               state_nxt.rdata            = `REG_RESET;
               state_nxt.rdata[EW-1:0]    = state_r.ev_sts;
            end
            `REG_EVMSK_OFS: begin
               state_nxt.rdata            = `REG_RESET;
               state_nxt.rdata[EW-1:0]    = state_r.ev_msk;
            end
            default: begin
               state_nxt.rdata = `REG_RESET; // unmapped reads return zero
            end
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rdata     = state_r.rdata;
   assign exp_in_values = state_r.in_val;
   assign xfer_req      = state_r.req;
   assign xfer_init     = state_r.x_init;
   assign xfer_addr     = state_r.x_addr;
   assign xfer_wdata    = state_r.x_wdata;
   assign busy          = (state_r.st != smbus_io_expander_pkg::XF_IDLE);
   assign irq           = |(state_r.ev_sts & state_r.ev_msk); // level while any unmasked event

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_read_view;
      reg_rd && (reg_addr == `REG_CTRL_OFS) |=> reg_rdata[`CTRL_PIN_LSB +: PW] == $past(pin_view);
   endproperty
   a_read_view: assert property (p_read_view) else $error("pin field read mismatch"); // [R1]

   property p_no_write_plain;
      ctrl_wr && !reg_wdata[`CTRL_TEST_BIT] |=> state_r.tst_out == $past(state_r.tst_out);
   endproperty
   a_no_write_plain: assert property (p_no_write_plain) else $error("pin write taken outside test"); // [R2]

   property p_test_drive;
      take_ref && state_r.test |=> xfer_req && (xfer_wdata == $past(state_r.tst_out[launch_id]));
   endproperty
   a_test_drive: assert property (p_test_drive) else $error("test values not sent"); // [R3]

   property p_inputs_fixed;
      1'b1 |=> (state_r.tst_out & INPUT_MASK) == ($past(state_r.tst_out) & INPUT_MASK);
   endproperty
   a_inputs_fixed: assert property (p_inputs_fixed) else $error("input bit written"); // [R4]

   property p_refresh_launch;
      ctrl_wr && reg_wdata[`CTRL_RELOAD_BIT] && sel_ok(wsel) && !busy && !state_r.pend_ref
         && !(|state_r.pend_init) |-> ##[1:3] xfer_req;
   endproperty
   a_refresh_launch: assert property (p_refresh_launch) else $error("refresh not launched"); // [R5] [R7]

   property p_reload_reads_zero;
      reg_rd |=> !reg_rdata[`CTRL_RELOAD_BIT];
   endproperty
   a_reload_reads_zero: assert property (p_reload_reads_zero) else $error("refresh bit read as one"); // [R6]

   property p_reserved_sel;
      reg_rd && (reg_addr == `REG_CTRL_OFS) && !sel_ok(state_r.sel) |=> reg_rdata[`CTRL_PIN_LSB +: PW] == '0;
   endproperty
   a_reserved_sel: assert property (p_reserved_sel) else $error("reserved select shows data"); // [R8]

   property p_done_refresh;
      finish && !state_r.cur_init && ({1'b0, state_r.cur} == state_r.sel) |=> state_r.done;
   endproperty
   a_done_refresh: assert property (p_done_refresh) else $error("completion not set"); // [R9] [R10]

   property p_done_init;
      finish && state_r.cur_init && ({1'b0, state_r.cur} == state_r.sel) |=> state_r.done;
   endproperty
   a_done_init: assert property (p_done_init) else $error("init completion not set"); // [R11]

   property p_done_clear;
      ctrl_wr && reg_wdata[`CTRL_DONE_BIT] && !finish |=> !state_r.done;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("completion not cleared"); // [R12]

   property p_done_keep;
      ctrl_wr && !reg_wdata[`CTRL_DONE_BIT] && state_r.done |=> state_r.done;
   endproperty
   a_done_keep: assert property (p_done_keep) else $error("completion lost on zero write"); // [R12]

   property p_bus_addr;
      $rose(xfer_req) |-> xfer_addr == $past(state_r.bus_addr[launch_id]);
   endproperty
   a_bus_addr: assert property (p_bus_addr) else $error("wrong expander address"); // [R13]

   c_refresh_done: cover property (finish && !state_r.cur_init);
   c_init_done:    cover property (finish && state_r.cur_init);
   c_test_write:   cover property (ctrl_wr && reg_wdata[`CTRL_TEST_BIT] && reg_wdata[`CTRL_RELOAD_BIT]);
   c_irq:          cover property ($rose(irq));

endmodule : smbus_io_expander_control

// File: sim/link_engine_model.sv
// link engine model: answers each transfer request with one framed 16-bit reply
`timescale 1ns/10ps
module link_engine_model (
   input  wire logic        xfer_req,
   input  wire logic [15:0] reply,
   input  wire logic [7:0]  gap,
   output logic             link_clk,
   output logic             link_frame,
   output logic             link_bit
);
   // ********
   // framing: clock stands still outside frames, gap gives prompt or slow answers
   // ********
   initial begin
      link_clk = 1'b0;
      link_frame = 1'b0;
      link_bit = 1'b0;
      forever begin
         @(posedge xfer_req);
         #(gap * 20 + 5); // off the block's clock edges, so sampling never races a change
         link_frame = 1'b1;
         for (int i = 15; i >= 0; i--) begin
            link_bit = reply[i]; // msb first
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
         end
         #80 link_frame = 1'b0;
         link_bit = ~link_bit; // released line must not show a stale value
      end
   end
endmodule : link_engine_model

// File: sim/smbus_io_expander_control_test.sv
// bench of the expander control block: random refreshes, test writes, init and events
`timescale 1ns/10ps
`include "expander_cfg.svh"
module smbus_io_expander_control_test;
   localparam logic [79:0] INMASK = `INPUT_MASK_DEF;
   logic        clk, rst, reg_wr, reg_rd, link_clk, link_frame, link_bit;
   logic        xfer_req, xfer_init, busy, irq, t;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val, seed;
   logic [79:0] core_out, exp_in_values;
   logic [6:0]  xfer_addr, a0;
   logic [15:0] xfer_wdata, reply, tv, outv, m;
   logic [7:0]  gap;
   int          failures, total_checks, cycles, e;
   smbus_io_expander_control DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_out(core_out),
      .exp_in_values(exp_in_values), .link_clk(link_clk), .link_frame(link_frame), .link_bit(link_bit),
      .xfer_req(xfer_req), .xfer_init(xfer_init), .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata),
      .busy(busy), .irq(irq));
   link_engine_model engine (.xfer_req(xfer_req), .reply(reply), .gap(gap), .link_clk(link_clk),
      .link_frame(link_frame), .link_bit(link_bit));
   // ********
   // helpers
   // ********
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk); // a quiet edge, so back-to-back writes never set the strobe twice in one step
   endtask : wr
   // read data lands at the edge that takes the strobe, sample just after it
   task automatic rd(input logic [11:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : rd
   // idle means ten quiet cycles, so queued transfers cannot slip past
   task automatic wait_idle;
      int q;
      q = 0;
      while (q < 10) begin
         @(posedge clk);
         #1 q = (busy === 1'b0) ? q + 1 : 0;
      end
   endtask : wait_idle
   function automatic logic [31:0] exp_ctrl(input int x, input logic tm, input logic [15:0] o);
      exp_ctrl = {1'b1, 1'b0, 4'(x), tm, 1'b0, 8'h00, (reply & m) | (o & ~m)};
   endfunction : exp_ctrl
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // ********
   // clock, timeout, sequence
   // ********
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run;
      end
   end
   initial begin
      seed = 32'h1C8B;
      {reg_wr, reg_rd, reg_addr, reg_wdata, core_out, reply, gap} = '0;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`REG_CTRL_OFS);
      check(rd_val, `REG_RESET);
      rd(12'hFFC);
      check(rd_val, 32'h0);
      wr(`REG_EVMSK_OFS, 32'h3);
      for (int n = 0; n < 8; n++) begin
         e = (n == 0) ? 4 : $unsigned($random(seed)) % 5;
         t = n[0];
         tv = 16'($random(seed));
         reply <= 16'($random(seed));
         gap <= 8'(n * 3);
         core_out <= 80'({$random(seed), $random(seed), $random(seed)});
         wr(`REG_CTRL_OFS, {2'b00, 4'(e), t, 1'b1, 8'h00, tv});
         wait_idle;
         m = INMASK[16*e +: 16];
         outv = t ? tv : core_out[16*e +: 16];
         check(32'(xfer_wdata & ~m), 32'(outv & ~m));
         check(32'(exp_in_values[16*e +: 16]), 32'(reply));
         check(32'(irq), 32'h1);
         rd(`REG_CTRL_OFS);
         check(rd_val, exp_ctrl(e, t, outv));
         wr(`REG_CTRL_OFS, {2'b00, 4'(e), t, 1'b0, 8'h00, tv});
         rd(`REG_CTRL_OFS);
         check(32'(rd_val[31]), 32'h1);
         wr(`REG_CTRL_OFS, {2'b10, 4'(e), t, 1'b0, 8'h00, tv});
         rd(`REG_CTRL_OFS);
         check(32'(rd_val[31]), 32'h0);
         wr(`REG_EVSTS_OFS, 32'h3);
         rd(`REG_EVSTS_OFS);
         check({rd_val[31:1], irq}, 32'h0);
      end
      // reserved select must not launch anything
      wr(`REG_CTRL_OFS, 32'h1500_0000);
      repeat (4) @(posedge clk);
      check(32'({busy, xfer_req}), 32'h0);
      rd(`REG_CTRL_OFS);
      check(rd_val, 32'h1400_0000);
      wr(`REG_CTRL_OFS, 32'h0);
      a0 = 7'($random(seed));
      wr(`REG_ADDR0_OFS, 32'({$random(seed), a0, 1'b0}));
      wait (xfer_req === 1'b1);
      #1 check(32'({xfer_init, xfer_addr}), {24'h0, 1'b1, a0});
      wait_idle;
      rd(`REG_CTRL_OFS);
      check(32'({rd_val[31], irq}), 32'h3);
      complete_run;
   end
endmodule : smbus_io_expander_control_test
